// *** src/otg_pkg.sv ***
package otg_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_EVENTS  = 8'h08;
    localparam logic [7:0] OFS_EV_EN   = 8'h0c;
    localparam logic [7:0] OFS_TIMER   = 8'h10;
    localparam logic [7:0] OFS_TMR_CNT = 8'h14;

    // control bit positions
    localparam int CTL_DRV_VBUS    = 0;
    localparam int CTL_VBUS_CHARGE = 1;
    localparam int CTL_VBUS_DISCH  = 2;
    localparam int CTL_LOCAL_CONN  = 4;
    localparam int CTL_SEL_SRP     = 9;
    localparam int CTL_SRP_DET_EN  = 10;
    localparam int CTL_HNP_EN      = 11;
    localparam int CTL_TMR_START   = 12;
    localparam logic [15:0] CTL_RESET   = 16'h0000;
    localparam logic [15:0] CTL_WR_MASK = 16'h1e17;

    // status bit positions
    localparam int ST_ROLE_PIN   = 0;
    localparam int ST_A_VBUS_VLD = 1;
    localparam int ST_B_SESS_END = 2;
    localparam int ST_A_SESS_VLD = 3;
    localparam int ST_B_SESS_VLD = 4;
    localparam int ST_CONNECT    = 5;
    localparam int ST_SUSPEND    = 6;
    localparam int ST_RESUME     = 7;
    localparam int ST_SRP_DET    = 8;
    localparam int ST_SE0_LONG   = 9;
    localparam int ST_BITS       = 10;
    localparam int EV_TIMER      = 10;
    localparam int EV_BITS       = 11;

    // timing, clock 200 MHz
    localparam int CLK_MHZ            = 200;
    localparam int TICK_NS            = 10000;
    localparam int TICK_CYC           = TICK_NS * CLK_MHZ / 1000;
    localparam int SE0_LONG_US        = 2000;
    localparam int IDLE_B_US          = 5000;
    localparam int IDLE_A_US          = 3000;
    localparam int SETTLE_US          = 30;
    localparam int PULSE_MIN_US       = 1000;
    localparam int SE0_LONG_CYC       = SE0_LONG_US * CLK_MHZ;
    localparam int IDLE_B_CYC         = IDLE_B_US * CLK_MHZ + 1;
    localparam int IDLE_A_CYC         = IDLE_A_US * CLK_MHZ + 1;
    localparam int SETTLE_CYC         = SETTLE_US * CLK_MHZ;
    localparam int PULSE_MIN_CYC      = PULSE_MIN_US * CLK_MHZ;

    typedef enum logic [2:0] {
        HNP_IDLE   = 3'b000,
        HNP_B_OFF  = 3'b001,
        HNP_B_WAIT = 3'b011,
        HNP_B_HOST = 3'b010,
        HNP_A_PERI = 3'b110,
        HNP_A_WAIT = 3'b111
    } hnp_state_t;

    // line pins after synchroniser: dp, dm, vbus comparators, role pin
    typedef struct packed {
        logic role_pin;
        logic dp;
        logic dm;
        logic a_vbus_vld;
        logic a_sess_vld;
        logic b_sess_vld;
        logic b_sess_end;
    } line_t;

    typedef struct packed {
        logic       dp_pullup;
        logic       dm_pullup;
        logic       drive_vbus;
        logic       vbus_charge;
        logic       vbus_discharge;
        logic       bus_reset;
    } phy_ctl_t;

endpackage

// *** src/otg_session_role_control.sv ***
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module otg_session_role_control (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire otg_pkg::line_t       line_in,
    output otg_pkg::phy_ctl_t         phy_ctl,
    output logic                      event_pending
);

    typedef struct packed {
        otg_pkg::line_t     s1;
        otg_pkg::line_t     s2;
        otg_pkg::line_t     s3;
        logic               aw_got;
        logic [7:0]         aw_addr;
        logic               w_got;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               bvalid;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [1:0]         bresp;
        logic [15:0]        ctl;
        logic [9:0]         stat;
        logic [10:0]        events;
        logic [10:0]        ev_en;
        logic [15:0]        tmr_load;
        logic [15:0]        tmr_cnt;
        logic [11:0]        tick_cnt;
        logic               tmr_run;
        logic [19:0]        idle_cnt;
        logic [19:0]        se0_cnt;
        logic [19:0]        pulse_cnt;
        logic               srp_det;
        otg_pkg::hnp_state_t hnp;
        logic [13:0]        settle_cnt;
        otg_pkg::phy_ctl_t  phy;
        logic               irq;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // a level from a pin counts once the 2nd and 3rd stage agree; dp and dm follow the 3rd stage alone
    function automatic logic agreed(input logic a, input logic b, input logic prev);
        agreed = (a == b) ? a : prev;
    endfunction

    // saturating counter step used by all the line timers
    function automatic logic [19:0] count_up(input logic [19:0] c, input logic run);
        count_up = !run ? 20'h0_0000 : ((c == 20'hf_ffff) ? c : c + 20'h0_0001);
    endfunction

    // register map read, shared by read path
    function automatic logic [31:0] reg_read(input state_t s, input logic [7:0] a);
        case (a)
            otg_pkg::OFS_CONTROL: reg_read = {16'h0000, s.ctl};
            otg_pkg::OFS_STATUS:  reg_read = {22'h00_0000, s.stat};
            otg_pkg::OFS_EVENTS:  reg_read = {21'h00_0000, s.events};
            otg_pkg::OFS_EV_EN:   reg_read = {21'h00_0000, s.ev_en};
            otg_pkg::OFS_TIMER:   reg_read = {16'h0000, s.tmr_load};
            otg_pkg::OFS_TMR_CNT: reg_read = {16'h0000, s.tmr_cnt};
            default:              reg_read = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == otg_pkg::OFS_CONTROL) || (a == otg_pkg::OFS_STATUS) ||
                 (a == otg_pkg::OFS_EVENTS) || (a == otg_pkg::OFS_EV_EN) ||
                 (a == otg_pkg::OFS_TIMER) || (a == otg_pkg::OFS_TMR_CNT);
    endfunction

    logic                 role_b;
    logic                 bus_idle;
    logic                 se0;
    logic                 j_state;
    logic                 wr_fire;
    logic [9:0]           new_stat;
    logic [15:0]          wmask;
    otg_pkg::line_t       ln;

    always_comb begin
        nxt_st = st_ff;
        // three-stage synchroniser; s1 is read only by s2
        nxt_st.s1 = line_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        ln.role_pin   = agreed(st_ff.s2.role_pin, st_ff.s3.role_pin, st_ff.stat[0]);
        ln.dp         = agreed(st_ff.s2.dp, st_ff.s3.dp, st_ff.s3.dp);
        ln.dm         = agreed(st_ff.s2.dm, st_ff.s3.dm, st_ff.s3.dm);
        ln.a_vbus_vld = agreed(st_ff.s2.a_vbus_vld, st_ff.s3.a_vbus_vld, st_ff.stat[1]);
        ln.b_sess_end = agreed(st_ff.s2.b_sess_end, st_ff.s3.b_sess_end, st_ff.stat[2]);
        ln.a_sess_vld = agreed(st_ff.s2.a_sess_vld, st_ff.s3.a_sess_vld, st_ff.stat[3]);
        ln.b_sess_vld = agreed(st_ff.s2.b_sess_vld, st_ff.s3.b_sess_vld, st_ff.stat[4]);
        role_b   = ln.role_pin;
        se0      = !ln.dp && !ln.dm;
        j_state  = ln.dp && !ln.dm;
        bus_idle = j_state || se0;

        // line timers: idle (line at J or SE0), long SE0, pulse presence
        nxt_st.idle_cnt = count_up(st_ff.idle_cnt, bus_idle && (ln.dp == st_ff.s3.dp));
        nxt_st.se0_cnt  = count_up(st_ff.se0_cnt, se0);

        // session request detection, select and enable
        if (st_ff.ctl[otg_pkg::CTL_SEL_SRP]) begin
            // data-line pulse on either line while not driving
            nxt_st.pulse_cnt = count_up(st_ff.pulse_cnt, ln.dp || ln.dm);
        end else begin
            nxt_st.pulse_cnt = count_up(st_ff.pulse_cnt, ln.a_sess_vld);
        end
        nxt_st.srp_det = st_ff.ctl[otg_pkg::CTL_SRP_DET_EN] && !role_b &&
                         !st_ff.phy.drive_vbus &&
                         (st_ff.pulse_cnt >= 20'(otg_pkg::PULSE_MIN_CYC));

        // status word
        new_stat = {st_ff.se0_cnt >= 20'(otg_pkg::SE0_LONG_CYC), st_ff.srp_det,
                    st_ff.hnp == otg_pkg::HNP_B_HOST || st_ff.hnp == otg_pkg::HNP_A_WAIT,
                    st_ff.idle_cnt >= 20'(otg_pkg::IDLE_A_CYC), j_state,
                    ln.b_sess_vld, ln.a_sess_vld, ln.b_sess_end, ln.a_vbus_vld,
                    ln.role_pin};
        nxt_st.stat = new_stat;

        // programmable timer in 0.01 ms ticks
        nxt_st.tick_cnt = 12'h000;
        if (st_ff.tmr_run) begin
            if (st_ff.tick_cnt == 12'(otg_pkg::TICK_CYC - 1)) begin
                nxt_st.tmr_cnt = st_ff.tmr_cnt + 16'h0001;
            end else begin
                nxt_st.tick_cnt = st_ff.tick_cnt + 12'h001;
            end
        end
        nxt_st.tmr_run = st_ff.ctl[otg_pkg::CTL_TMR_START] &&
                         (st_ff.tmr_cnt < st_ff.tmr_load);
        if (!st_ff.ctl[otg_pkg::CTL_TMR_START]) begin
            nxt_st.tmr_cnt = 16'h0000; // count clears whenever the start bit is clear
        end

        // negotiation sequencer
        nxt_st.settle_cnt = 14'h0000;
        case (st_ff.hnp)
            otg_pkg::HNP_IDLE: begin
                if (role_b && st_ff.ctl[otg_pkg::CTL_HNP_EN] &&
                    st_ff.idle_cnt >= 20'(otg_pkg::IDLE_B_CYC)) begin
                    nxt_st.hnp = otg_pkg::HNP_B_OFF;
                end else if (!role_b && st_ff.ctl[otg_pkg::CTL_HNP_EN] && se0 &&
                             st_ff.phy.drive_vbus) begin
                    nxt_st.hnp = otg_pkg::HNP_A_PERI;
                end
            end
            otg_pkg::HNP_B_OFF: begin
                nxt_st.settle_cnt = st_ff.settle_cnt + 14'h0001;
                if (st_ff.settle_cnt >= 14'(otg_pkg::SETTLE_CYC) && j_state) begin
                    nxt_st.hnp = otg_pkg::HNP_B_HOST;
                end else if (!st_ff.ctl[otg_pkg::CTL_HNP_EN]) begin
                    nxt_st.hnp = otg_pkg::HNP_IDLE;
                end
            end
            otg_pkg::HNP_B_HOST: begin
                if (!st_ff.ctl[otg_pkg::CTL_HNP_EN] || !ln.b_sess_vld) begin
                    nxt_st.hnp = otg_pkg::HNP_IDLE;
                end
            end
            otg_pkg::HNP_A_PERI: begin
                if (st_ff.idle_cnt >= 20'(otg_pkg::IDLE_A_CYC) && se0 == 1'b0 &&
                    !j_state) begin
                    nxt_st.hnp = otg_pkg::HNP_A_PERI;
                end else if (st_ff.idle_cnt >= 20'(otg_pkg::IDLE_A_CYC)) begin
                    nxt_st.hnp = otg_pkg::HNP_A_WAIT;
                end
                if (!st_ff.ctl[otg_pkg::CTL_HNP_EN]) begin
                    nxt_st.hnp = otg_pkg::HNP_IDLE;
                end
            end
            otg_pkg::HNP_A_WAIT: begin
                if (j_state) begin
                    nxt_st.settle_cnt = st_ff.settle_cnt + 14'h0001;
                end
                if (st_ff.settle_cnt >= 14'(otg_pkg::SETTLE_CYC) && j_state) begin
                    nxt_st.hnp = otg_pkg::HNP_IDLE;
                end
            end
            default: nxt_st.hnp = otg_pkg::HNP_IDLE;
        endcase

        // pin controls follow control bits and sequencer
        nxt_st.phy.drive_vbus = st_ff.ctl[otg_pkg::CTL_DRV_VBUS] && !role_b;
        // charge follows its bit in either role, so a write alone moves it
        nxt_st.phy.vbus_charge = st_ff.ctl[otg_pkg::CTL_VBUS_CHARGE];
        nxt_st.phy.vbus_discharge = st_ff.ctl[otg_pkg::CTL_VBUS_DISCH];
        nxt_st.phy.dm_pullup = 1'b0; // own pulsing always on DP
        nxt_st.phy.dp_pullup = st_ff.ctl[otg_pkg::CTL_LOCAL_CONN] ||
                               (role_b && ln.b_sess_vld && st_ff.hnp == otg_pkg::HNP_IDLE) ||
                               st_ff.hnp == otg_pkg::HNP_A_PERI;
        nxt_st.phy.bus_reset = (st_ff.hnp == otg_pkg::HNP_B_HOST) ||
                               (st_ff.hnp == otg_pkg::HNP_A_WAIT &&
                                nxt_st.hnp == otg_pkg::HNP_IDLE);
        // session ends with VBUS: drop the negotiation
        if (!ln.a_sess_vld && !ln.b_sess_vld) begin
            nxt_st.hnp = otg_pkg::HNP_IDLE;
        end

        // AXI write: address and data in either order
        wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        wmask = {{8{st_ff.w_strb[1]}}, {8{st_ff.w_strb[0]}}};
        // events: set on status change, set wins over write-one clear
        nxt_st.events = st_ff.events;
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = mapped(st_ff.aw_addr) ? 2'b00 : 2'b10;
            case (st_ff.aw_addr)
                otg_pkg::OFS_CONTROL: nxt_st.ctl = (st_ff.ctl & ~(wmask & otg_pkg::CTL_WR_MASK))
                    | (st_ff.w_data[15:0] & wmask & otg_pkg::CTL_WR_MASK);
                otg_pkg::OFS_EVENTS:  nxt_st.events = st_ff.events &
                    ~(st_ff.w_data[10:0] & {wmask[10:8], wmask[7:0]});
                otg_pkg::OFS_EV_EN:   nxt_st.ev_en = (st_ff.ev_en & ~wmask[10:0]) |
                    (st_ff.w_data[10:0] & wmask[10:0]);
                otg_pkg::OFS_TIMER:   nxt_st.tmr_load = (st_ff.tmr_load & ~wmask) |
                    (st_ff.w_data[15:0] & wmask);
                default: ;
            endcase
        end
        nxt_st.events[9:0] = nxt_st.events[9:0] | (new_stat ^ st_ff.stat);
        nxt_st.events[otg_pkg::EV_TIMER] = nxt_st.events[otg_pkg::EV_TIMER] |
            (st_ff.tmr_run && !nxt_st.tmr_run && st_ff.ctl[otg_pkg::CTL_TMR_START]);
        nxt_st.irq = |(st_ff.events & st_ff.ev_en);
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // AXI read: one-cycle arready, data valid in the same cycle
        nxt_st.arready = 1'b0;
        if (s_axi_arvalid && !st_ff.arready && !st_ff.rvalid) begin
            nxt_st.arready = 1'b1;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rdata   = reg_read(st_ff, s_axi_araddr);
            nxt_st.rresp   = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
    end

    // all state in one register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.stat[otg_pkg::ST_ROLE_PIN] <= 1'b1; // pin reads B for one cycle, then A from the zeroed s2 and s3 until the pin arrives
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready  = !st_ff.w_got;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign phy_ctl       = st_ff.phy;
    assign event_pending = st_ff.irq;

endmodule

// *** verif/otg_role_properties.sv ***
`timescale 1ns/1ps
module otg_role_properties (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [7:0]        s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire otg_pkg::line_t    line_in,
    input wire otg_pkg::phy_ctl_t phy_ctl
);
    // single domain, so clock and reset are stated once
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // answers stand until taken, and a write answer comes after its data
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
    a_wresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
    a_bresp_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_wvalid && s_axi_wready, 3)) else $error("write answer without data");
    // register map edges
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
    a_mapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h14 && s_axi_araddr[1:0] == 2'b00 |-> s_axi_rresp == 2'b00) else $error("mapped read refused");
    // line side
    a_dm_never: assert property (!phy_ctl.dm_pullup) else $error("dm pull-up driven");
    a_b_no_vbus: assert property (line_in.role_pin && $past(line_in.role_pin) && $past(line_in.role_pin, 2) && $past(line_in.role_pin, 3) && $past(line_in.role_pin, 4) |-> !phy_ctl.drive_vbus) else $error("vbus driven as b-device");
    // vbus charge and discharge move only by a software write
    a_charge_by_wr: assert property (!$stable(phy_ctl.vbus_charge) |-> $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_wvalid && s_axi_wready, 3)) else $error("charge changed without write");
    a_disch_by_wr: assert property (!$stable(phy_ctl.vbus_discharge) |-> $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_wvalid && s_axi_wready, 3)) else $error("discharge changed without write");
endmodule

bind otg_session_role_control otg_role_properties i_props (
    .aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .phy_ctl
);

// *** verif/otg_far_side.sv ***
`timescale 1ns/1ps
module otg_far_side (
    input  wire logic              aclk,
    input  wire otg_pkg::phy_ctl_t phy,
    input  wire logic              plug_a,
    input  wire logic              peer_pull,
    output otg_pkg::line_t         line
);
    initial line = '0;
    // levels settle a cycle after their cause, like the analog path
    always @(posedge aclk) begin
        line.role_pin   <= !plug_a;                  // mini-A plug grounds the pin
        // peer never sources vbus, levels follow our drive alone
        line.a_vbus_vld <= phy.drive_vbus;
        line.a_sess_vld <= phy.drive_vbus;
        line.b_sess_vld <= phy.drive_vbus;
        line.b_sess_end <= !phy.drive_vbus;
        line.dp         <= phy.dp_pullup || peer_pull;
        line.dm         <= 1'b0;                     // pull-downs hold dm low
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic              aclk;
    logic              aresetn;
    logic [7:0]        s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [7:0]        s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    otg_pkg::line_t    line_in;
    otg_pkg::phy_ctl_t phy_ctl;
    logic              event_pending;
    logic              plug_a;
    logic              peer_pull;
    int                mismatches;
    int                n_tests;
    logic [31:0]       rd;
    logic [1:0]        resp;

    otg_session_role_control i_otg_session_role_control (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .phy_ctl, .event_pending
    );
    otg_far_side i_otg_far_side (.aclk, .phy(phy_ctl), .plug_a, .peer_pull, .line(line_in));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // a hung handshake counts against the run and closes it
    task automatic timed_out;
        mismatches++;
        $display("CHECK FAILED handshake expected answer seen none");
        end_sim;
    endtask

    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n == 100) timed_out();
    endtask

    task automatic rdreg(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        if (n == 100) timed_out();
    endtask

    // main sequence: reset, role b, role a controls, events, timer, refusals
    initial begin
        {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        plug_a = 1'b0;
        peer_pull = 1'b0;
        mismatches = 0;
        n_tests = 0;
        wait_cyc(20);
        aresetn <= 1'b1;
        wait_cyc(10);
        rdreg(otg_pkg::OFS_CONTROL);
        check("control reset", rd, {16'h0000, otg_pkg::CTL_RESET});
        rdreg(otg_pkg::OFS_STATUS);
        check("role pin b", rd[otg_pkg::ST_ROLE_PIN], 1'b1);
        check("session end b", rd[otg_pkg::ST_B_SESS_END], 1'b1);
        wr(otg_pkg::OFS_CONTROL, 32'h0000_0001);
        wait_cyc(10);
        check("vbus drive as b", phy_ctl.drive_vbus, 1'b0);
        $display("test b_role done");
        plug_a <= 1'b1;
        wait_cyc(10);
        wr(otg_pkg::OFS_CONTROL, 32'hffff_ffff);
        rdreg(otg_pkg::OFS_CONTROL);
        check("control mask", rd, {16'h0000, otg_pkg::CTL_WR_MASK});
        wr(otg_pkg::OFS_CONTROL, 32'h0000_0017);
        wait_cyc(10);
        check("vbus drive as a", phy_ctl.drive_vbus, 1'b1);
        check("dp pulsing", phy_ctl.dp_pullup, 1'b1);
        check("dm kept off", phy_ctl.dm_pullup, 1'b0);
        rdreg(otg_pkg::OFS_STATUS);
        check("a session levels", rd[4:0], 5'b11010);
        wait_cyc(200);
        check("charge held", phy_ctl.vbus_charge, 1'b1);
        check("discharge held", phy_ctl.vbus_discharge, 1'b1);
        wr(otg_pkg::OFS_CONTROL, 32'h0000_0000);
        wait_cyc(10);
        check("charge off", phy_ctl.vbus_charge, 1'b0);
        $display("test a_controls done");
        wr(otg_pkg::OFS_EV_EN, 32'h0000_07ff);
        wr(otg_pkg::OFS_EVENTS, 32'h0000_07ff);
        rdreg(otg_pkg::OFS_EVENTS);
        check("events cleared", rd[10:0], 11'h000);
        plug_a <= 1'b0;
        wait_cyc(10);
        rdreg(otg_pkg::OFS_EVENTS);
        check("role change flag", rd[otg_pkg::ST_ROLE_PIN], 1'b1);
        check("pending on", event_pending, 1'b1);
        wr(otg_pkg::OFS_EV_EN, 32'h0000_0000);
        wait_cyc(5);
        check("pending masked", event_pending, 1'b0);
        wr(otg_pkg::OFS_EVENTS, 32'h0000_0001);
        rdreg(otg_pkg::OFS_EVENTS);
        check("flag cleared", rd[otg_pkg::ST_ROLE_PIN], 1'b0);
        $display("test events done");
        // three ticks of 2000 cycles: silent at 4000, flagged by 7000
        wr(otg_pkg::OFS_TIMER, 32'h0000_0003);
        wr(otg_pkg::OFS_EVENTS, 32'h0000_07ff);
        wr(otg_pkg::OFS_CONTROL, 32'h0000_1000);
        wait_cyc(4000);
        rdreg(otg_pkg::OFS_EVENTS);
        check("timer early", rd[otg_pkg::EV_TIMER], 1'b0);
        wait_cyc(3000);
        rdreg(otg_pkg::OFS_EVENTS);
        check("timer expiry", rd[otg_pkg::EV_TIMER], 1'b1);
        wr(otg_pkg::OFS_CONTROL, 32'h0000_0000);
        $display("test timer done");
        rdreg(8'h20);
        check("unmapped read resp", resp, 2'b10);
        check("unmapped read data", rd, 32'h0000_0000);
        wr(8'h20, 32'hffff_ffff);
        check("unmapped write resp", resp, 2'b10);
        rdreg(otg_pkg::OFS_CONTROL);
        check("control untouched", rd, 32'h0000_0000);
        $display("test refusals done");
        end_sim();
    end
endmodule
